// *** osu_partner.sv ***
// Oscillator waveform and PLL lock model standing beyond the block
`timescale 1ns/10ps
`default_nettype none
module osu_partner (
    input wire logic sys_clk_i,
    input wire logic run_i,
    input wire logic lock_i,
    output logic osc_tick_o,
    output logic pll_lock_raw_o
);
    logic [1:0] div = 2'h0;
    logic tick_q = 1'b0;
    ////////////////////////////////////////////////////////////////
    // Crystal waveform, four cycles high and four low, still when stopped
    always @(posedge sys_clk_i) begin
        div <= run_i ? div + 2'h1 : 2'h0;
        if (!run_i) begin
            tick_q <= 1'b0;
        end else if (div == 2'h3) begin
            tick_q <= ~tick_q;
        end
    end
    assign osc_tick_o = tick_q;
    // Loop lock state as the testbench commands it
    assign pll_lock_raw_o = lock_i;
endmodule
`default_nettype wire

// *** osu_pkg.sv ***
// Shared constants for oscillator selection and start-up logic
package osu_pkg;
    // Widths
    localparam int GROUP_W = 3;
    localparam int MODE_W = 5;
    localparam int TRIM_W = 6;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int OST_W = 10;
    localparam int PCT_W = 9;

    // Oscillator group codes
    localparam logic [2:0] GRP_SECONDARY = 3'h0;
    localparam logic [2:0] GRP_FAST_RC = 3'h1;
    localparam logic [2:0] GRP_SLOW_RC = 3'h2;
    localparam logic [2:0] GRP_PRIMARY = 3'h3;
    localparam logic [2:0] GRP_PRIMARY_PLL = 3'h7;

    // Primary-mode codes without PLL
    localparam logic [4:0] MODE_XTL = 5'h00;
    localparam logic [4:0] MODE_HS = 5'h02;
    localparam logic [4:0] MODE_XT = 5'h04;
    localparam logic [4:0] MODE_EXT_RC_IO_MODE = 5'h08;
    localparam logic [4:0] MODE_ERC = 5'h09;
    localparam logic [4:0] MODE_EC = 5'h0B;
    localparam logic [4:0] MODE_EXT_CLOCK_IO_MODE = 5'h0C;
    // Primary-mode codes through the PLL
    localparam logic [4:0] MODE_FRC_PLL4 = 5'h05;
    localparam logic [4:0] MODE_FRC_PLL8 = 5'h06;
    localparam logic [4:0] MODE_FRC_PLL16 = 5'h07;
    localparam logic [4:0] MODE_EXT_CLOCK_IO_MODE_PLL4 = 5'h0D;
    localparam logic [4:0] MODE_EXT_CLOCK_IO_MODE_PLL8 = 5'h0E;
    localparam logic [4:0] MODE_EXT_CLOCK_IO_MODE_PLL16 = 5'h0F;
    localparam logic [4:0] MODE_HS2_PLL4 = 5'h11;
    localparam logic [4:0] MODE_HS2_PLL8 = 5'h12;
    localparam logic [4:0] MODE_HS2_PLL16 = 5'h13;
    localparam logic [4:0] MODE_HS3_PLL4 = 5'h15;
    localparam logic [4:0] MODE_HS3_PLL8 = 5'h16;
    localparam logic [4:0] MODE_HS3_PLL16 = 5'h17;

    // Device clock source reported on clk_src_o
    localparam logic [2:0] SRC_NONE = 3'h0;
    localparam logic [2:0] SRC_SECONDARY = 3'h1;
    localparam logic [2:0] SRC_FAST_RC = 3'h2;
    localparam logic [2:0] SRC_SLOW_RC = 3'h3;
    localparam logic [2:0] SRC_PRIMARY = 3'h4;
    localparam logic [2:0] SRC_PLL = 3'h5;

    // PLL gain codes
    localparam logic [1:0] MULT_NONE = 2'h0;
    localparam logic [1:0] MULT_X4 = 2'h1;
    localparam logic [1:0] MULT_X8 = 2'h2;
    localparam logic [1:0] MULT_X16 = 2'h3;

    // Second oscillator pin functions
    localparam logic [1:0] OSC_OUT_PIN_IO = 2'h0;
    localparam logic [1:0] OSC_OUT_PIN_CLKOUT = 2'h1;
    localparam logic [1:0] OSC_OUT_PIN_OSC = 2'h2;

    // Start-up count in oscillator cycles
    localparam logic [9:0] OST_LAST = 10'h3FF;
    localparam logic [9:0] OST_ZERO = 10'h000;

    // Trim step in tenths of a percent
    localparam int TRIM_STEP_TENTHS = 4;

    // Register byte addresses
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_TRIM = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;

    // Control register fields
    localparam int CTRL_REQ_LSB = 0;
    localparam int CTRL_KEEP_BIT = 3;
    // Status register fields
    localparam int STAT_CUR_LSB = 0;
    localparam int STAT_LOCK_BIT = 3;
    localparam int STAT_MODE_LSB = 4;
    localparam int STAT_REL_BIT = 9;

    // Reset values
    localparam logic [2:0] GROUP_RST = 3'h0;
    localparam logic [4:0] MODE_RST = 5'h00;
    localparam logic [5:0] TRIM_RST = 6'h00;
    localparam logic [15:0] DATA_ZERO = 16'h0000;
endpackage

// *** osu_startup.sv ***
// Crystal start-up counter gating the oscillator clock
`timescale 1ns/10ps
`default_nettype none
module osu_startup (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic restart_i,
    input wire logic tick_i,
    output logic done_o
);
    logic [osu_pkg::OST_W-1:0] count;

    // Count oscillator cycles from zero after each restart
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count <= osu_pkg::OST_ZERO;
            done_o <= 1'b0;
        end else if (restart_i) begin
            count <= osu_pkg::OST_ZERO;
            done_o <= 1'b0;
        end else if (tick_i && !done_o) begin
            count <= count + 10'h001;
            done_o <= (count == osu_pkg::OST_LAST);
        end
    end

    // Done only on the tick that completes the full count
    chk_count_full: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        $rose(done_o) |-> $past(count == osu_pkg::OST_LAST && tick_i && !restart_i))
        else $error("start-up done without full count");
endmodule
`default_nettype wire

// *** osu_sync.sv ***
// Three-flop input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module osu_sync (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic async_i,
    output logic sync_o
);
    logic stage1;
    logic stage2;
    logic stage3;

    // Chain of three flops; only stage2 reads stage1
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else begin
            stage1 <= async_i;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Accept a new level once the second and third stages agree
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync_o <= 1'b0;
        end else if (stage2 == stage3) begin
            sync_o <= stage2;
        end
    end
endmodule
`default_nettype wire

// *** osu_top.sv ***
// Oscillator source selection, start-up gating, PLL lock and fast RC trim
// What this block does
// - At reset release choose clock source from group field and primary-mode field.
// - Group codes pick secondary, fast RC, slow RC, primary, primary through PLL.
// - Second oscillator pin function follows primary mode: I/O, clock out or oscillator.
// - First oscillator pin is never general I/O.
// - Start-up counter is ten bits and counts 1024 oscillator cycles.
// - Start-up count applies to crystal modes at reset and each wake-up.
// - Secondary oscillator runs, even in sleep, while keep-on bit is one.
// - Secondary drives the device clock only with group 000 and keep-on set.
// - Returning from secondary to main oscillator reapplies the start-up delay.
// - PLL gain is four, eight or sixteen, chosen by the mode encoding.
// - Lock indication rises when the PLL locks.
// - Lock indication falls on loss of lock; software reads it as status.
// - Group status 001 runs the device from the fast internal RC.
// - Group 111 with modes 00101, 00110, 00111 gives fast RC times 4, 8, 16.
// - Software writes a six-bit fast RC trim field.
// - Trim is two's complement in 0.4 percent steps around calibration.
// - At reset both current and requested group load from the group field.
`timescale 1ns/10ps
`default_nettype none
module osu_top (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic [osu_pkg::GROUP_W-1:0] osc_group_cfg_i,
    input wire logic [osu_pkg::MODE_W-1:0] primary_mode_cfg_i,
    input wire logic osc_tick_i,
    input wire logic pll_lock_raw_i,
    input wire logic wake_i,
    input wire logic [osu_pkg::ADDR_W-1:0] addr_i,
    input wire logic [osu_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [osu_pkg::DATA_W-1:0] rdata_o,
    output logic [2:0] clk_src_o,
    output logic [1:0] pll_mult_o,
    output logic [1:0] osc_out_pin_func_o,
    output logic osc_in_pin_is_osc_o,
    output logic secondary_osc_en_o,
    output logic osc_clk_release_o,
    output logic lock_o,
    output logic [osu_pkg::TRIM_W-1:0] trim_step_o,
    output logic [osu_pkg::PCT_W-1:0] trim_tenth_pct_o
);
    typedef enum logic [2:0] {
        ST_LOAD = 3'b001,
        ST_WAIT = 3'b010,
        ST_RUN = 3'b100
    } osu_state_e;

    osu_state_e state;
    osu_state_e next_state;
    logic [2:0] current_group_status;
    logic [2:0] requested_group;
    logic [4:0] primary_mode;
    logic secondary_osc_keep_on;
    logic [5:0] fast_rc_trim;
    logic tick_stable;
    logic tick_prev;
    logic tick_pulse;
    logic lock_stable;
    logic ost_done;
    logic restart;
    logic return_from_secondary;
    logic ctrl_wr;
    logic needs_ost;
    logic [2:0] next_src;
    logic [1:0] next_mult;
    logic [1:0] next_osc_out_pin;
    logic mode_crystal;
    localparam int PCT_W = osu_pkg::PCT_W;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers and start-up counter
    osu_sync u_tick_sync (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .async_i(osc_tick_i),
        .sync_o(tick_stable)
    );

    osu_sync u_lock_sync (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .async_i(pll_lock_raw_i),
        .sync_o(lock_stable)
    );

    // Rising edge of the filtered oscillator level is one cycle
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tick_prev <= 1'b0;
        end else begin
            tick_prev <= tick_stable;
        end
    end
    assign tick_pulse = tick_stable && !tick_prev;

    // Restart on load, wake-up and return from the secondary group
    assign ctrl_wr = wr_i && (addr_i == osu_pkg::ADDR_CTRL);
    assign return_from_secondary = ctrl_wr && (requested_group == osu_pkg::GRP_SECONDARY)
        && (wdata_i[osu_pkg::CTRL_REQ_LSB +: osu_pkg::GROUP_W] != osu_pkg::GRP_SECONDARY);
    assign restart = (state == ST_LOAD) || wake_i || return_from_secondary;

    osu_startup u_startup (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .restart_i(restart),
        .tick_i(tick_pulse),
        .done_o(ost_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Mode decode: crystal flag, PLL gain, second pin function
    always_comb begin
        mode_crystal = 1'b0;
        next_mult = osu_pkg::MULT_NONE;
        next_osc_out_pin = osu_pkg::OSC_OUT_PIN_OSC;
        case (primary_mode)
            osu_pkg::MODE_XTL, osu_pkg::MODE_XT, osu_pkg::MODE_HS: begin
                mode_crystal = 1'b1;
            end
            osu_pkg::MODE_EC, osu_pkg::MODE_ERC: begin
                next_osc_out_pin = osu_pkg::OSC_OUT_PIN_CLKOUT;
            end
            osu_pkg::MODE_EXT_CLOCK_IO_MODE, osu_pkg::MODE_EXT_RC_IO_MODE: begin
                next_osc_out_pin = osu_pkg::OSC_OUT_PIN_IO;
            end
            osu_pkg::MODE_FRC_PLL4, osu_pkg::MODE_EXT_CLOCK_IO_MODE_PLL4: begin
                next_osc_out_pin = osu_pkg::OSC_OUT_PIN_IO;
                next_mult = osu_pkg::MULT_X4;
            end
            osu_pkg::MODE_FRC_PLL8, osu_pkg::MODE_EXT_CLOCK_IO_MODE_PLL8: begin
                next_osc_out_pin = osu_pkg::OSC_OUT_PIN_IO;
                next_mult = osu_pkg::MULT_X8;
            end
            osu_pkg::MODE_FRC_PLL16, osu_pkg::MODE_EXT_CLOCK_IO_MODE_PLL16: begin
                next_osc_out_pin = osu_pkg::OSC_OUT_PIN_IO;
                next_mult = osu_pkg::MULT_X16;
            end
            osu_pkg::MODE_HS2_PLL4, osu_pkg::MODE_HS3_PLL4: begin
                mode_crystal = 1'b1;
                next_mult = osu_pkg::MULT_X4;
            end
            osu_pkg::MODE_HS2_PLL8, osu_pkg::MODE_HS3_PLL8: begin
                mode_crystal = 1'b1;
                next_mult = osu_pkg::MULT_X8;
            end
            osu_pkg::MODE_HS2_PLL16, osu_pkg::MODE_HS3_PLL16: begin
                mode_crystal = 1'b1;
                next_mult = osu_pkg::MULT_X16;
            end
            default: begin
                next_osc_out_pin = osu_pkg::OSC_OUT_PIN_OSC;
            end
        endcase
    end

    // Group decides the source; mode field ignored outside primary groups
    always_comb begin
        next_src = osu_pkg::SRC_NONE;
        needs_ost = 1'b0;
        if (current_group_status == osu_pkg::GRP_SECONDARY) begin
            next_src = secondary_osc_keep_on ? osu_pkg::SRC_SECONDARY : osu_pkg::SRC_NONE;
            needs_ost = 1'b1;
        end else if (current_group_status == osu_pkg::GRP_FAST_RC) begin
            next_src = osu_pkg::SRC_FAST_RC;
        end else if (current_group_status == osu_pkg::GRP_SLOW_RC) begin
            next_src = osu_pkg::SRC_SLOW_RC;
        end else if (current_group_status == osu_pkg::GRP_PRIMARY) begin
            next_src = osu_pkg::SRC_PRIMARY;
            needs_ost = mode_crystal && (next_mult == osu_pkg::MULT_NONE);
        end else if (current_group_status == osu_pkg::GRP_PRIMARY_PLL) begin
            next_src = (next_mult == osu_pkg::MULT_NONE) ? osu_pkg::SRC_NONE : osu_pkg::SRC_PLL;
            needs_ost = mode_crystal;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: load configuration, wait start-up, run
    always_comb begin
        next_state = state;
        case (state)
            ST_LOAD: begin
                next_state = ST_WAIT;
            end
            ST_WAIT: begin
                if (!needs_ost || ost_done) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (restart && needs_ost) begin
                    next_state = ST_WAIT;
                end
            end
            default: begin
                next_state = ST_LOAD;
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= ST_LOAD;
        end else begin
            state <= next_state;
        end
    end

    // Configuration captured on the first edge after reset release
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            current_group_status <= osu_pkg::GROUP_RST;
            primary_mode <= osu_pkg::MODE_RST;
        end else if (state == ST_LOAD) begin
            current_group_status <= osc_group_cfg_i;
            primary_mode <= primary_mode_cfg_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software registers
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            requested_group <= osu_pkg::GROUP_RST;
            secondary_osc_keep_on <= 1'b0;
        end else if (state == ST_LOAD) begin
            requested_group <= osc_group_cfg_i;
        end else if (ctrl_wr) begin
            requested_group <= wdata_i[osu_pkg::CTRL_REQ_LSB +: osu_pkg::GROUP_W];
            secondary_osc_keep_on <= wdata_i[osu_pkg::CTRL_KEEP_BIT];
        end
    end

    // Fast RC trim field
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fast_rc_trim <= osu_pkg::TRIM_RST;
        end else if (wr_i && (addr_i == osu_pkg::ADDR_TRIM)) begin
            fast_rc_trim <= wdata_i[osu_pkg::TRIM_W-1:0];
        end
    end

    // Read data one cycle after the strobe, zero elsewhere
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= osu_pkg::DATA_ZERO;
        end else begin
            rdata_o <= osu_pkg::DATA_ZERO;
            if (rd_i && (addr_i == osu_pkg::ADDR_CTRL)) begin
                rdata_o[osu_pkg::CTRL_REQ_LSB +: osu_pkg::GROUP_W] <= requested_group;
                rdata_o[osu_pkg::CTRL_KEEP_BIT] <= secondary_osc_keep_on;
            end else if (rd_i && (addr_i == osu_pkg::ADDR_TRIM)) begin
                rdata_o[osu_pkg::TRIM_W-1:0] <= fast_rc_trim;
            end else if (rd_i && (addr_i == osu_pkg::ADDR_STATUS)) begin
                rdata_o[osu_pkg::STAT_CUR_LSB +: osu_pkg::GROUP_W] <= current_group_status;
                rdata_o[osu_pkg::STAT_LOCK_BIT] <= lock_o;
                rdata_o[osu_pkg::STAT_MODE_LSB +: osu_pkg::MODE_W] <= primary_mode;
                rdata_o[osu_pkg::STAT_REL_BIT] <= osc_clk_release_o;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            clk_src_o <= osu_pkg::SRC_NONE;
            pll_mult_o <= osu_pkg::MULT_NONE;
            osc_out_pin_func_o <= osu_pkg::OSC_OUT_PIN_OSC;
            osc_in_pin_is_osc_o <= 1'b1;
            secondary_osc_en_o <= 1'b0;
            osc_clk_release_o <= 1'b0;
            lock_o <= 1'b0;
            trim_step_o <= osu_pkg::TRIM_RST;
            trim_tenth_pct_o <= {osu_pkg::PCT_W{1'b0}};
        end else begin
            clk_src_o <= next_src;
            pll_mult_o <= (current_group_status == osu_pkg::GRP_PRIMARY_PLL) ? next_mult : osu_pkg::MULT_NONE;
            osc_out_pin_func_o <= next_osc_out_pin;
            osc_in_pin_is_osc_o <= 1'b1;
            secondary_osc_en_o <= secondary_osc_keep_on;
            osc_clk_release_o <= (next_state == ST_RUN);
            lock_o <= lock_stable && (current_group_status == osu_pkg::GRP_PRIMARY_PLL);
            trim_step_o <= fast_rc_trim;
            trim_tenth_pct_o <= PCT_W'($signed(fast_rc_trim) * osu_pkg::TRIM_STEP_TENTHS);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_load;
        state == ST_LOAD;
    endsequence
    sequence s_lock_up;
        $rose(lock_stable) && current_group_status == osu_pkg::GRP_PRIMARY_PLL;
    endsequence

    chk_load_groups: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        s_load |=> (current_group_status == $past(osc_group_cfg_i)) && (requested_group == $past(osc_group_cfg_i)))
        else $error("groups not loaded from configuration");
    chk_osc_in_pin_never_io: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        osc_in_pin_is_osc_o) else $error("first oscillator pin released as I/O");
    chk_keep_on_en: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        secondary_osc_keep_on |=> secondary_osc_en_o) else $error("secondary oscillator not kept on");
    chk_secondary_src: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        clk_src_o == osu_pkg::SRC_SECONDARY
        |-> $past(secondary_osc_keep_on && current_group_status == osu_pkg::GRP_SECONDARY))
        else $error("secondary drives clock without its conditions");
    chk_fast_rc_src: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        current_group_status == osu_pkg::GRP_FAST_RC |=> clk_src_o == osu_pkg::SRC_FAST_RC)
        else $error("fast RC not selected for group 001");
    chk_pll_gain: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (current_group_status == osu_pkg::GRP_PRIMARY_PLL && primary_mode == osu_pkg::MODE_FRC_PLL16)
        |=> pll_mult_o == osu_pkg::MULT_X16 && clk_src_o == osu_pkg::SRC_PLL)
        else $error("fast RC sixteen-times PLL not applied");
    chk_lock_rise: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        s_lock_up |=> lock_o)
        else $error("lock indication did not rise with PLL lock");
    chk_lock_fall: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        $fell(lock_stable) |=> !lock_o)
        else $error("lock indication did not drop on loss of lock");
    chk_ost_hold: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        ($rose(osc_clk_release_o) && $past(needs_ost)) |-> $past(ost_done))
        else $error("clock released before start-up count");
    chk_wake_gate: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (restart && needs_ost && state == ST_RUN) |=> ##1 !osc_clk_release_o)
        else $error("restart did not gate the clock");
    chk_trim_sign: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        ($signed(trim_tenth_pct_o) < 0) == $past(fast_rc_trim[5]))
        else $error("trim decode sign wrong");
endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking testbench for oscillator selection and start-up
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic sys_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [2:0] grp = 3'h0;
    logic [4:0] mode = 5'h00;
    logic wake = 1'b0, run = 1'b0, lock_req = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata, d;
    logic tick, lock_raw, osc_in_pin, sec_en, rel, lock;
    logic [2:0] clk_src;
    logic [1:0] mult, osc_out_pin;
    logic [5:0] tstep;
    logic [8:0] tpct;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;
    ////////////////////////////////////////////////////////////////
    osu_top dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .osc_group_cfg_i(grp), .primary_mode_cfg_i(mode),
        .osc_tick_i(tick), .pll_lock_raw_i(lock_raw), .wake_i(wake), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .clk_src_o(clk_src), .pll_mult_o(mult), .osc_out_pin_func_o(osc_out_pin),
        .osc_in_pin_is_osc_o(osc_in_pin), .secondary_osc_en_o(sec_en), .osc_clk_release_o(rel), .lock_o(lock),
        .trim_step_o(tstep), .trim_tenth_pct_o(tpct));
    osu_partner partner (.sys_clk_i(sys_clk_i), .run_i(run), .lock_i(lock_req), .osc_tick_o(tick),
        .pll_lock_raw_o(lock_raw));
    ////////////////////////////////////////////////////////////////
    // Clock and cycle ceiling
    always #2 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            summarize();
        end
    end
    task automatic summarize();
        if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Reset with the configuration fields set, then settle
    task automatic do_reset(input logic [2:0] g, input logic [4:0] m);
        @(posedge sys_clk_i);
        arst_n_i <= 1'b0;
        grp <= g;
        mode <= m;
        run <= 1'b0;
        repeat (12) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
        @(posedge sys_clk_i);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge sys_clk_i);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge sys_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // Run the crystal and see release only after the 1024th cycle
    task automatic wait_start();
        @(posedge sys_clk_i);
        run <= 1'b1;
        repeat (1023) @(posedge tick);
        repeat (6) @(posedge sys_clk_i);
        check(rel, 1'b0);
        @(posedge tick);
        repeat (12) @(posedge sys_clk_i);
        check(rel, 1'b1);
        run <= 1'b0;
    endtask
    // Source, gain and pin decode for each non-crystal selection
    task automatic t_groups();
        logic [14:0] tbl [11] = '{{3'h1, 5'h0C, 3'h2, 2'h0, 2'h0}, {3'h2, 5'h0B, 3'h3, 2'h0, 2'h1},
            {3'h7, 5'h0D, 3'h5, 2'h1, 2'h0}, {3'h7, 5'h0E, 3'h5, 2'h2, 2'h0},
            {3'h3, 5'h0C, 3'h4, 2'h0, 2'h0}, {3'h3, 5'h09, 3'h4, 2'h0, 2'h1}, {3'h3, 5'h08, 3'h4, 2'h0, 2'h0},
            {3'h7, 5'h05, 3'h5, 2'h1, 2'h0}, {3'h7, 5'h06, 3'h5, 2'h2, 2'h0}, {3'h7, 5'h07, 3'h5, 2'h3, 2'h0},
            {3'h7, 5'h0F, 3'h5, 2'h3, 2'h0}};
        for (int i = 0; i < 11; i++) begin
            do_reset(tbl[i][14:12], tbl[i][11:7]);
            check({clk_src, mult, osc_out_pin}, tbl[i][6:0]);
            check({osc_in_pin, rel}, 2'h3);
            rd_reg(osu_pkg::ADDR_STATUS);
            check(d, {6'h00, 1'b1, tbl[i][11:7], 1'b0, tbl[i][14:12]});
            rd_reg(osu_pkg::ADDR_CTRL);
            check(d, {13'h0000, tbl[i][14:12]});
        end
    endtask
    // Gating at reset, on return from secondary and on wake
    task automatic t_startup();
        do_reset(osu_pkg::GRP_PRIMARY_PLL, osu_pkg::MODE_HS3_PLL16);
        check({rel, clk_src, mult, osc_out_pin}, {1'b0, osu_pkg::SRC_PLL, osu_pkg::MULT_X16, osu_pkg::OSC_OUT_PIN_OSC});
        do_reset(osu_pkg::GRP_PRIMARY, osu_pkg::MODE_XT);
        check({rel, osc_out_pin}, {1'b0, osu_pkg::OSC_OUT_PIN_OSC});
        wait_start();
        wr_reg(osu_pkg::ADDR_CTRL, 16'h0000);
        wr_reg(osu_pkg::ADDR_CTRL, 16'h0003);
        repeat (4) @(posedge sys_clk_i);
        check(rel, 1'b0);
        wait_start();
        @(posedge sys_clk_i);
        wake <= 1'b1;
        @(posedge sys_clk_i);
        wake <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        check(rel, 1'b0);
        wait_start();
        do_reset(osu_pkg::GRP_FAST_RC, 5'h0C);
        @(posedge sys_clk_i);
        wake <= 1'b1;
        @(posedge sys_clk_i);
        wake <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        check(rel, 1'b1);
    endtask
    // Keep-on bit runs the secondary and makes it the clock
    task automatic t_secondary();
        do_reset(osu_pkg::GRP_SECONDARY, 5'h00);
        check({sec_en, clk_src}, {1'b0, osu_pkg::SRC_NONE});
        wr_reg(osu_pkg::ADDR_CTRL, 16'h0008);
        repeat (3) @(posedge sys_clk_i);
        check({sec_en, clk_src}, {1'b1, osu_pkg::SRC_SECONDARY});
        wr_reg(osu_pkg::ADDR_CTRL, 16'h0000);
        repeat (3) @(posedge sys_clk_i);
        check(sec_en, 1'b0);
    endtask
    // Lock follows the loop and is read-only status
    task automatic t_lock();
        do_reset(osu_pkg::GRP_PRIMARY_PLL, osu_pkg::MODE_FRC_PLL4);
        @(posedge sys_clk_i);
        lock_req <= 1'b1;
        repeat (8) @(posedge sys_clk_i);
        check(lock, 1'b1);
        wr_reg(osu_pkg::ADDR_STATUS, 16'h0000);
        rd_reg(osu_pkg::ADDR_STATUS);
        check(d, 16'h025F);
        @(posedge sys_clk_i);
        lock_req <= 1'b0;
        #1 check(rdata, 16'h0000);
        repeat (8) @(posedge sys_clk_i);
        check(lock, 1'b0);
        rd_reg(4'hC);
        check(d, 16'h0000);
    endtask
    // Trim codes at both ends and around zero, outside the sixteen-times loop
    task automatic t_trim();
        logic [5:0] v [5] = '{6'h1F, 6'h20, 6'h00, 6'h3F, 6'h01};
        int s;
        do_reset(osu_pkg::GRP_FAST_RC, 5'h0C);
        for (int i = 0; i < 5; i++) begin
            s = v[i][5] ? int'(v[i]) - 64 : int'(v[i]);
            wr_reg(osu_pkg::ADDR_TRIM, {10'h000, v[i]});
            rd_reg(osu_pkg::ADDR_TRIM);
            check(d, {10'h000, v[i]});
            check({tstep, tpct}, {v[i], 9'(s * 4)});
        end
    endtask
    initial begin
        t_groups();
        t_startup();
        t_secondary();
        t_lock();
        t_trim();
        summarize();
    end
endmodule
`default_nettype wire
